// *** inc/spi_pin_params.svh ***
// Constants for the multi-line serial pin front end
// What this block does
// [R1] Third pin: protect input or data line two
// [R2] Host drives protect pin during register writes
// [R3] Fourth pin is data only quad, selected
// [R4] Reset enabled, quad off: fourth pin resets
// [R5] Quad on: fourth pin resets only deselected
// [R6] Single-bit commands: in on zero, out one
// [R7] Multi-line instruction byte on line zero only
// [R8] Host sends pairs or nibbles for address/data
// [R9] Device returns pairs or nibbles of read data
// [R10] Quad-peripheral mode: everything in nibbles
// [R11] Inputs sampled on rising serial clock
// [R12] Outputs change after falling, or every edge
// [R13] Deselected: ignore inputs, outputs high impedance
// [R14] Deselected and idle: enter standby
// [R15] Busy flag held during embedded operation
// [R16] Select low: active mode, command transfer
// [R17] No command before first select fall
// [R18] Protect low blocks status/config-one writes silently; code blocks only with status_write_disable_bit set and quad mode off
// [R19] Reset needs select high, pin low long
// [R20] Select rise returns lines to input
`ifndef SPI_PIN_PARAMS_SVH
`define SPI_PIN_PARAMS_SVH
`define CLK_PERIOD_NS     10
`define RESET_PULSE_NS    200
`define RESET_PULSE_CYC   ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INSTR_BITS        8
`define QUAD_BIT_POS      1
`define RESET_EN_BIT_POS  5
`define SWD_BIT_POS       7
`define BUSY_BIT_POS      1
`endif

// *** inc/spi_pin_pkg.sv ***
// Types for the multi-line serial pin front end
package spi_pin_pkg;
  typedef enum logic [1:0] {
    WIDTH_ONE  = 2'h0,
    WIDTH_TWO  = 2'h1,
    WIDTH_FOUR = 2'h3
  } lane_width_t;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'h0,
    PH_INSTR = 2'h1,
    PH_BODY  = 2'h3,
    PH_OUT   = 2'h2
  } phase_t;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe_n;
  } lane_drive_t;

  typedef struct packed {
    logic quad_mode;
    logic reset_pin_en;
    logic status_write_disable_bit;
    logic quad_peripheral_mode;
    logic double_rate;
  } pin_cfg_t;
endpackage

// *** hdl/spi_pin_sync.sv ***
// Two-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
module spi_pin_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Pins
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) begin
      $error("spi_pin_sync: WIDTH must be positive");
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta     <= rst_val;
      sync_out <= rst_val;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// *** hdl/spi_pin_front_end.sv ***
// Pin role assignment and lane shifting for the multi-line serial slave
`timescale 1ns/1ps
`include "spi_pin_params.svh"
module spi_pin_front_end #(
  parameter int RESET_CYC = `RESET_PULSE_CYC
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Pins to and from host
  input  wire logic                   sck,
  input  wire logic                   cs_n,
  input  wire logic [3:0]             data_line_i,
  output logic      [3:0]             data_line_o,
  output logic      [3:0]             data_line_oe_n,
  // Configuration
  input  wire spi_pin_pkg::pin_cfg_t  cfg,
  input  wire spi_pin_pkg::lane_width_t body_width,
  // Core side
  input  wire logic                   embedded_busy,
  input  wire logic                   reg_write_req,
  input  wire logic                   reg_write_targets_one,
  input  wire logic                   out_start,
  input  wire logic [7:0]             out_byte,
  output logic                        out_taken,
  output logic [7:0]                  instr_byte,
  output logic                        instr_valid,
  output logic [3:0]                  body_nibble,
  output logic                        body_valid,
  output logic                        reg_write_allowed,
  output logic                        write_protect_level,
  output logic                        hw_reset,
  output logic                        write_in_progress_flag,
  output logic                        standby,
  output logic                        armed
);
  import spi_pin_pkg::*;

  initial begin
    if (RESET_CYC < 1) begin
      $error("spi_pin_front_end: RESET_CYC must be at least one");
    end
    if (RESET_CYC > 255) begin
      $error("spi_pin_front_end: RESET_CYC must fit eight bits");
    end
  end

  // Synchronised pins
  logic [5:0] pins_s;
  spi_pin_sync #(.WIDTH(6)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({sck, cs_n, data_line_i}),
    .rst_val  (6'h1f),
    .sync_out (pins_s)
  );

  wire       sck_s  = pins_s[5];
  wire       cs_s   = pins_s[4];
  wire [3:0] din    = pins_s[3:0];

  logic       sck_d;
  logic       cs_d;
  wire        sck_rise = sck_s & ~sck_d;
  wire        sck_fall = ~sck_s & sck_d;
  wire        cs_fall  = ~cs_s & cs_d;
  wire        cs_rise  = cs_s & ~cs_d;
  wire        selected = ~cs_s & armed;

  // Pin roles
  wire wp_role    = ~cfg.quad_mode;                             // see [R1]
  wire line3_data = cfg.quad_mode & ~cs_s;                      // see [R3]
  wire rst_role   = cfg.reset_pin_en & (~cfg.quad_mode | cs_s); // see [R4] see [R5]

  // Lane count of a body width
  function automatic logic [2:0] lanes_of(input lane_width_t w);
    case (w)
      WIDTH_TWO: begin
        lanes_of = 3'h2;
      end
      WIDTH_FOUR: begin
        lanes_of = 3'h4;
      end
      default: begin
        lanes_of = 3'h1;
      end
    endcase
  endfunction

  // Lines used for a lane count; one lane answers on line one
  function automatic logic [3:0] lane_use(input logic [2:0] lanes);
    case (lanes)
      3'h4: begin
        lane_use = 4'hf;
      end
      3'h2: begin
        lane_use = 4'h3;
      end
      default: begin
        lane_use = 4'h2;
      end
    endcase
  endfunction

  // Pin image of the top bits of the output shifter
  function automatic logic [3:0] lane_image(input logic [2:0] lanes, input logic [7:0] sh);
    case (lanes)
      3'h4: begin
        lane_image = sh[7:4];
      end
      3'h2: begin
        lane_image = {2'h0, sh[7:6]};
      end
      default: begin
        lane_image = {2'h0, sh[7], 1'b0};
      end
    endcase
  endfunction

  phase_t     phase;
  phase_t     next_phase;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] out_sh;
  logic [3:0] out_cnt;
  logic [7:0] rst_cnt;
  logic [3:0] lane_allow;
  logic [3:0] next_oe_n;
  logic [3:0] body_next;

  wire        instr_quad  = cfg.quad_peripheral_mode;          // see [R10]
  wire [2:0]  in_lanes    = (phase == PH_INSTR) ? (instr_quad ? 3'h4 : 3'h1) // see [R7]
                          : (instr_quad ? 3'h4 : lanes_of(body_width));      // see [R8]
  wire [2:0]  out_lanes   = instr_quad ? 3'h4 : lanes_of(body_width);         // see [R9]
  wire [3:0]  next_bits   = bit_cnt + {1'b0, in_lanes};
  wire [3:0]  next_out    = out_cnt + {1'b0, out_lanes};
  wire        out_edge    = cfg.double_rate ? (sck_rise | sck_fall) : sck_fall; // see [R12]
  wire [7:0]  instr_next  = (in_lanes == 3'h4) ? {shreg[3:0], din}
                          : {shreg[6:0], din[0]};
  wire [3:0]  out_image   = lane_image(out_lanes, out_sh);     // see [R6] see [R9]
  wire [3:0]  out_used    = lane_use(out_lanes);
  wire [7:0]  out_shifted = out_sh << out_lanes;

  // Line two stays a protect input outside quad mode
  for (genvar g = 0; g < 4; g++) begin : g_lane
    if (g == 3) begin : g_three
      assign lane_allow[g] = line3_data;                        // see [R3]
    end else if (g == 2) begin : g_two
      assign lane_allow[g] = cfg.quad_mode;                     // see [R1]
    end else begin : g_low
      assign lane_allow[g] = 1'b1;
    end
    assign next_oe_n[g] = ~(out_used[g] & lane_allow[g]);
    assign body_next[g] = (g < in_lanes) ? din[g] : 1'b0;       // see [R8]
  end

  always_comb begin
    next_phase = phase;
    case (phase)
      PH_IDLE: begin
        if (selected) next_phase = PH_INSTR;                    // see [R16]
      end
      PH_INSTR: begin
        if (sck_rise && next_bits >= 4'h8) next_phase = PH_BODY;
      end
      PH_BODY: begin
        if (out_start) next_phase = PH_OUT;
      end
      PH_OUT: begin
        next_phase = PH_OUT;
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
    if (cs_s) begin
      next_phase = PH_IDLE;                                     // see [R13] see [R20]
    end
  end

  // Pin edge history
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sck_d <= sck_s;
      cs_d  <= cs_s;
    end
  end

  // First select fall arms the command decoder
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      armed <= 1'b0;
    end else if (cs_fall) begin
      armed <= 1'b1;                                            // see [R17]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase <= PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Input shifting on rising serial clock
  always_ff @(posedge clk) begin
    if (sys_rst || phase == PH_IDLE) begin
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      instr_valid <= 1'b0;
      body_valid  <= 1'b0;
      instr_byte  <= 8'h00;
      body_nibble <= 4'h0;
    end else begin
      instr_valid <= 1'b0;
      body_valid  <= 1'b0;
      if (sck_rise && phase == PH_INSTR) begin                  // see [R11]
        shreg   <= instr_next;
        bit_cnt <= next_bits;
        if (next_bits >= 4'h8) begin
          instr_byte  <= instr_next;
          instr_valid <= 1'b1;
        end
      end else if (sck_rise && phase == PH_BODY) begin          // see [R11]
        body_nibble <= body_next;
        body_valid  <= 1'b1;
      end
    end
  end

  // Output shifting
  always_ff @(posedge clk) begin
    if (sys_rst || phase != PH_OUT) begin
      out_sh         <= out_byte;
      out_cnt        <= 4'h0;
      out_taken      <= 1'b0;
      data_line_o    <= 4'h0;
      data_line_oe_n <= 4'hf;                                   // see [R13] see [R20]
    end else begin
      out_taken <= 1'b0;
      if (out_edge) begin                                       // see [R12]
        data_line_o    <= out_image;
        data_line_oe_n <= next_oe_n;                            // see [R1] see [R3]
        if (next_out >= 4'h8) begin
          out_sh    <= out_byte;
          out_cnt   <= 4'h0;
          out_taken <= 1'b1;
        end else begin
          out_sh  <= out_shifted;
          out_cnt <= next_out;
        end
      end
    end
  end

  // Protection, reset detect, status
  wire       write_blocked = reg_write_targets_one & wp_role
                           & cfg.status_write_disable_bit & ~din[2]; // see [R18]
  wire       rst_low       = rst_role & cs_s & ~din[3];         // see [R19]
  wire [7:0] rst_limit     = RESET_CYC[7:0];
  wire       rst_full      = rst_cnt >= rst_limit - 8'h01;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_cnt  <= 8'h00;
      hw_reset <= 1'b0;
    end else if (!rst_low) begin
      rst_cnt  <= 8'h00;
      hw_reset <= 1'b0;
    end else begin
      if (rst_cnt < rst_limit) begin
        rst_cnt <= rst_cnt + 8'h01;
      end
      hw_reset <= rst_full;                                     // see [R19]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      write_protect_level    <= 1'b1;
      reg_write_allowed      <= 1'b0;
      write_in_progress_flag <= 1'b0;
      standby                <= 1'b1;
    end else begin
      write_protect_level    <= wp_role ? din[2] : 1'b1;        // see [R1] see [R2]
      reg_write_allowed      <= reg_write_req & ~write_blocked; // see [R18]
      write_in_progress_flag <= embedded_busy;                  // see [R15]
      standby                <= cs_s & ~embedded_busy;          // see [R14] see [R16]
    end
  end
endmodule

// *** dv/spi_pin_front_end_assertions.sv ***
// Port checks for the pin front end
`timescale 1ns/1ps
module spi_pin_front_end_assertions #(
  parameter int RESET_CYC = 2
) (
  // Watched ports
  input wire logic           clk,
  input wire logic           sys_rst,
  input wire logic           cs_n,
  input wire logic [3:0]     data_line_i,
  input wire logic [3:0]     data_line_oe_n,
  input wire spi_pin_pkg::pin_cfg_t cfg,
  input wire logic           embedded_busy,
  input wire logic           instr_valid,
  input wire logic           hw_reset,
  input wire logic           write_in_progress_flag,
  input wire logic           standby,
  input wire logic           armed
);
  import spi_pin_pkg::*;
  logic [15:0] low_run;
  // Cycles with select high and line three low
  always_ff @(posedge clk) begin
    low_run <= (sys_rst | ~cs_n | data_line_i[3]) ? 16'h0000 : low_run + 16'h0001;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  chk_deselect_hiz: assert property (cs_n [*5] |-> data_line_oe_n == 4'hf)
    else $error("outputs driven while deselected");
  chk_standby_idle: assert property ((cs_n && !embedded_busy) [*5] |-> standby)
    else $error("no standby while idle");
  chk_select_active: assert property ((!cs_n) [*5] |-> !standby)
    else $error("standby while selected");
  chk_busy_flag: assert property (embedded_busy [*4] |-> write_in_progress_flag)
    else $error("busy flag low during operation");
  chk_upper_lanes_in: assert property ((!cfg.quad_mode) [*4] |-> &data_line_oe_n[3:2])
    else $error("upper lanes driven outside quad");
  chk_quad_no_reset: assert property ((cfg.quad_mode && !cs_n) [*5] |-> !hw_reset)
    else $error("reset taken while selected in quad");
  chk_reset_needs_en: assert property ((!cfg.reset_pin_en) [*4] |-> !hw_reset)
    else $error("reset taken while disabled");
  chk_reset_width: assert property ($rose(hw_reset) |-> low_run >= RESET_CYC)
    else $error("reset on too short a pulse");
  chk_first_select: assert property (instr_valid |-> armed)
    else $error("instruction before first select");
  cover property (instr_valid);
  cover property ($rose(hw_reset));
  cover property (!data_line_oe_n[3]);
endmodule

bind spi_pin_front_end spi_pin_front_end_assertions #(.RESET_CYC(RESET_CYC)) chk (.*);

// *** dv/spi_host_model.sv ***
// Behavioural host driving the serial pins
`timescale 1ns/1ps
module spi_host_model (
  // Pins
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] data_line_i,
  input wire logic [3:0] data_line_o
);
  logic [3:0] drv = 4'h0;
  logic [3:0] val = 4'hf;
  // Released: pull-ups on two and three, inverse of last value on zero and one
  assign data_line_i = {drv[3:2] & val[3:2] | ~drv[3:2], drv[1:0] & val[1:0] | ~drv[1:0] & ~val[1:0]};
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
  end
  task automatic hold(input logic [3:0] en, input logic [3:0] d);
    drv = en;
    val = d;
  endtask
  task automatic sel(input logic v);
    cs_n = v;
    #125;
  endtask
  task automatic tick(input logic [3:0] en, input logic [3:0] d, output logic [3:0] q);
    hold(en, d);
    #62.5 sck = 1'b1;
    q = data_line_o;
    #62.5 sck = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] b, input int w);
    logic [3:0] q;
    for (int i = 8 - w; i >= 0; i -= w) begin
      tick(w == 4 ? 4'hf : w == 2 ? 4'h3 : 4'h1,
           w == 4 ? b[i+:4] : w == 2 ? {2'b00, b[i+:2]} : {3'b000, b[i]}, q);
    end
  endtask
  task automatic get_byte(input int w, output logic [7:0] r);
    logic [3:0] q;
    r = 8'h00;
    for (int i = 0; i < 8; i += w) begin
      tick(4'h0, 4'h0, q);
      r = w == 4 ? {r[3:0], q} : w == 2 ? {r[5:0], q[1:0]} : {r[6:0], q[1]};
    end
  endtask
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the pin front end
`timescale 1ns/1ps
module testbench;
  import spi_pin_pkg::*;
  logic clk, sys_rst, sck, cs_n, embedded_busy, reg_write_req, reg_write_targets_one;
  logic out_start, out_taken, instr_valid, body_valid, reg_write_allowed;
  logic write_protect_level, hw_reset, write_in_progress_flag, standby, armed;
  logic [3:0] data_line_i, data_line_o, data_line_oe_n, body_nibble, nib;
  logic [7:0] out_byte, instr_byte, got, rd;
  pin_cfg_t cfg;
  lane_width_t body_width;
  int err_total = 0, check_count = 0, n_instr = 0, cyc = 0, n_taken = 0;
  spi_pin_front_end #(.RESET_CYC(4)) dut (.*);
  spi_host_model host (.sck, .cs_n, .data_line_i, .data_line_o);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (instr_valid) begin
      got <= instr_byte;
      n_instr <= n_instr + 1;
    end
    if (body_valid) nib <= body_nibble;
    if (out_taken) n_taken <= n_taken + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic at(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic frame(input logic [7:0] ins, input int iw, input int rw);
    host.sel(1'b0);
    host.put_byte(ins, iw);
    host.get_byte(rw, rd);
    host.sel(1'b1);
    at(6);
  endtask
  task automatic t_idle;
    host.put_byte(8'h3c, 1);
    at(6);
    chk("oe_n", 8'h0f, {4'h0, data_line_oe_n});
    chk("standby", 8'h01, {7'h00, standby});
    chk("instr count", 8'h00, n_instr[7:0]);
    chk("armed idle", 8'h00, {7'h00, armed});
    $display("idle done");
  endtask
  task automatic t_reads;
    out_start = 1'b1;
    out_byte = 8'ha5;
    frame(8'h3c, 1, 1);
    chk("single instr", 8'h3c, got);
    chk("single read", 8'ha5, rd);
    chk("oe_n after", 8'h0f, {4'h0, data_line_oe_n});
    chk("armed", 8'h01, {7'h00, armed});
    chk("bytes taken", 8'h01, n_taken[7:0]);
    body_width = WIDTH_TWO;
    frame(8'h3b, 1, 2);
    chk("dual read", 8'ha5, rd);
    cfg.quad_mode = 1'b1;
    body_width = WIDTH_FOUR;
    frame(8'heb, 1, 4);
    chk("quad read", 8'ha5, rd);
    cfg.quad_peripheral_mode = 1'b1;
    frame(8'hc7, 4, 4);
    chk("qpi instr", 8'hc7, got);
    chk("qpi read", 8'ha5, rd);
    cfg = '0;
    cfg.double_rate = 1'b1;
    body_width = WIDTH_ONE;
    frame(8'h0d, 1, 1);
    chk("ddr read", 8'hcc, rd);
    cfg = '0;
    out_start = 1'b0;
    $display("reads done");
  endtask
  task automatic t_body;
    cfg.quad_mode = 1'b1;
    cfg.reset_pin_en = 1'b1;
    body_width = WIDTH_FOUR;
    host.sel(1'b0);
    host.put_byte(8'h38, 1);
    host.put_byte(8'h96, 4);
    at(4);
    chk("body nibble", 8'h06, {4'h0, nib});
    chk("no reset", 8'h00, {7'h00, hw_reset});
    host.hold(4'h0, 4'hf);
    host.sel(1'b1);
    for (int q = 0; q < 2; q++) begin
      cfg.quad_mode = q[0];
      host.hold(4'h8, 4'h0);
      at(12);
      chk("reset held", 8'h01, {7'h00, hw_reset});
      host.hold(4'h0, 4'hf);
      at(6);
      chk("reset gone", 8'h00, {7'h00, hw_reset});
    end
    $display("body reset done");
  endtask
  task automatic t_protect;
    cfg = '0;
    cfg.status_write_disable_bit = 1'b1;
    {reg_write_req, reg_write_targets_one} = 2'h3;
    for (int v = 0; v < 2; v++) begin
      host.hold(4'h4, {1'b0, v[0], 2'h0});
      at(6);
      chk("write allowed", {7'h00, v[0]}, {7'h00, reg_write_allowed});
      chk("protect level", {7'h00, v[0]}, {7'h00, write_protect_level});
    end
    host.hold(4'h0, 4'hf);
    reg_write_req = 1'b0;
    embedded_busy = 1'b1;
    at(6);
    chk("busy flag", 8'h01, {7'h00, write_in_progress_flag});
    chk("busy standby", 8'h00, {7'h00, standby});
    embedded_busy = 1'b0;
    $display("protect busy done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    cfg = '0;
    body_width = WIDTH_ONE;
    {embedded_busy, reg_write_req, reg_write_targets_one, out_start} = 4'h0;
    out_byte = 8'h00;
    at(2);
    sys_rst = 1'b0;
    at(3);
    t_idle();
    t_reads();
    t_body();
    t_protect();
    end_of_test();
  end
endmodule
